// ==== design/sfd_pkg.sv ====
// Package for the serial flash device model: opcodes, table constants, erase timing.
// Assumes a single 100 MHz clock domain and no software-visible registers.
package sfd_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned NS_PER_MS          = 1000000;
    localparam int unsigned MS_PER_S           = 1000;
    localparam int unsigned BULK_MAX_S_16      = 50;
    localparam int unsigned BULK_MAX_S_32      = 100;
    localparam int unsigned BULK_MAX_S_64      = 200;
    localparam int unsigned SECTOR_MAX_MS_MIN  = 1000;
    localparam int unsigned SECTOR_MAX_MS      = 2000;
    localparam int unsigned SUBSECT_MAX_MS_MIN = 300;
    localparam int unsigned SUBSECT_MAX_MS     = 400;
    localparam int unsigned SUBSECT_TYP_MS     = 45;
    localparam int unsigned SECTOR_TYP_MS      = 150;

    // Cycle count of a time in ms, rounded down since these are maxima.
    function automatic longint unsigned sfd_ms_to_cycles(input longint unsigned ms);
        return (ms * NS_PER_MS) / CLK_PERIOD_NS;
    endfunction : sfd_ms_to_cycles

    // ------------------------------------------------------------------
    // Serial interface
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_READ_PARAM  = 8'h5A;
    localparam logic [7:0] OP_ERASE_BULK  = 8'hC7;
    localparam logic [7:0] OP_ERASE_SECT  = 8'hD8;
    localparam logic [7:0] OP_ERASE_SUB   = 8'h20;
    localparam int unsigned ADDR_BITS     = 24;
    localparam int unsigned PARAM_DUMMY   = 8;
    localparam logic [7:0] PARAM_FILL     = 8'hFF;
    localparam logic [7:0] PARAM_DENS_ADR = 8'h87;
    localparam logic [7:0] PARAM_SIZE_ADR = 8'hAB;

    // Density selector: 0..3 for 16, 32, 64, 128 megabit.
    typedef logic [1:0] sfd_density_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_OPC   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA  = 3'b100,
        ST_IGN   = 3'b101
    } sfd_state_type;

    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic mosi;
    } sfd_link_in_type;

endpackage : sfd_pkg

// ==== design/sfd_param_rom.sv ====
// Discoverable-parameter table ROM with a registered read port.
// Assumes data are wanted one cycle after the address is presented.
`timescale 1ns/100ps
`default_nettype none
module sfd_param_rom
    import sfd_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            srst,
    input  wire sfd_density_type density,
    input  wire logic [7:0]      addr,
    output logic      [7:0]      rdata
);
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = PARAM_FILL;
        case (addr)
            8'h00: next_rdata = 8'h53;
            8'h01: next_rdata = 8'h46;
            8'h02: next_rdata = 8'h44;
            8'h03: next_rdata = 8'h50;
            8'h04: next_rdata = 8'h05;
            8'h05: next_rdata = 8'h01;
            8'h06: next_rdata = 8'h00;
            8'h08: next_rdata = 8'h00;
            8'h09: next_rdata = 8'h05;
            8'h0A: next_rdata = 8'h01;
            8'h0B: next_rdata = 8'h10;
            8'h0C: next_rdata = 8'h80;
            8'h0D: next_rdata = 8'h00;
            8'h0E: next_rdata = 8'h00;
            8'h80: next_rdata = 8'hE5;
            8'h81: next_rdata = 8'h20;
            8'h82: next_rdata = 8'hF9;
            PARAM_DENS_ADR: begin
                case (density)
                    2'h0:    next_rdata = 8'h00;
                    2'h1:    next_rdata = 8'h01;
                    2'h2:    next_rdata = 8'h03;
                    default: next_rdata = 8'h07;
                endcase
            end
            8'h88: next_rdata = 8'h44;
            8'h89: next_rdata = 8'hEB;
            8'h8A: next_rdata = 8'h08;
            8'h8B: next_rdata = 8'h6B;
            8'h8C: next_rdata = 8'h08;
            8'h8D: next_rdata = 8'h3B;
            8'h8E: next_rdata = 8'h42;
            8'h8F: next_rdata = 8'hBB;
            8'h90: next_rdata = 8'hFE;
            8'h96: next_rdata = 8'h00;
            8'h97: next_rdata = 8'h00;
            8'h9A: next_rdata = 8'h40;
            8'h9B: next_rdata = 8'hEB;
            8'h9C: next_rdata = 8'h0C;
            8'h9D: next_rdata = 8'h20;
            8'h9E: next_rdata = 8'h0F;
            8'h9F: next_rdata = 8'h52;
            8'hA0: next_rdata = 8'h10;
            8'hA1: next_rdata = 8'hD8;
            8'hA2: next_rdata = 8'h00;
            8'hA3: next_rdata = 8'h00;
            8'hA4: next_rdata = 8'h36;
            8'hA5: next_rdata = 8'h02;
            8'hA6: next_rdata = 8'hA6;
            8'hA7: next_rdata = 8'h00;
            8'hA8: next_rdata = 8'h82;
            8'hA9: next_rdata = 8'hEA;
            8'hAA: next_rdata = 8'h14;
            PARAM_SIZE_ADR: begin
                case (density)
                    2'h0:    next_rdata = 8'hB3;
                    2'h1:    next_rdata = 8'hC2;
                    2'h2:    next_rdata = 8'hC4;
                    default: next_rdata = 8'hC9;
                endcase
            end
            8'hAC: next_rdata = 8'hE9;
            8'hAD: next_rdata = 8'h63;
            8'hAE: next_rdata = 8'h76;
            8'hAF: next_rdata = 8'h33;
            8'hB0: next_rdata = 8'h7A;
            8'hB1: next_rdata = 8'h75;
            8'hB2: next_rdata = 8'h7A;
            8'hB3: next_rdata = 8'h75;
            8'hB4: next_rdata = 8'hF7;
            8'hB5: next_rdata = 8'hA2;
            8'hB6: next_rdata = 8'hD5;
            8'hB7: next_rdata = 8'h5C;
            8'hB8: next_rdata = 8'h19;
            8'hB9: next_rdata = 8'hF7;
            8'hBA: next_rdata = 8'h4D;
            8'hBC: next_rdata = 8'hE9;
            8'hBD: next_rdata = 8'h30;
            8'hBE: next_rdata = 8'hF8;
            8'hBF: next_rdata = 8'h80;
            default: next_rdata = PARAM_FILL;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata <= PARAM_FILL;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule : sfd_param_rom
`default_nettype wire

// ==== design/sfd_flash_core.sv ====
// Serial flash device core: decodes the serial command stream, answers the
// parameter-table read and runs erase-busy timers.
// Assumes serial inputs are synchronous to ref_clk and far slower than it.
//
// Functional notes
// - Bulk erase completes within 50, 100 or 200 s by density; the default bulk timer is 200 s for every density.
// - Sector erase completes within 1000 ms smallest, 2000 ms larger members.
// - Subsector erase completes within 300 ms smallest, 400 ms larger members.
// - Opcode 5Ah with address returns parameter table bytes from that address on.
// - Table addresses 00h-03h return 53h 46h 44h 50h.
// - Table addresses 04h-0Fh return the fixed header bytes.
// - Table addresses 10h-7Fh read as FFh.
// - Table 80h-86h return E5h 20h F9h then four FFh.
// - Table 87h encodes density 00h 01h 03h 07h.
// - Table 88h-8Fh advertise fast-read variants.
// - Table 90h-9Bh return the fixed descriptor bytes.
// - Table 9Ch-A3h give erase size and opcode pairs.
// - Table A4h-AAh return fixed bytes.
// - Table ABh returns B3h C2h C4h or C9h by density.
// - Table ACh-B5h return fixed bytes.
`timescale 1ns/100ps
`default_nettype none
module sfd_flash_core
    import sfd_pkg::*;
#(
    parameter sfd_density_type DENSITY        = 2'h3,
    parameter longint unsigned BULK_CYCLES    = sfd_ms_to_cycles(longint'(BULK_MAX_S_64) * MS_PER_S),
    parameter longint unsigned SECTOR_CYCLES  = sfd_ms_to_cycles(longint'(SECTOR_TYP_MS)),
    parameter longint unsigned SUBSECT_CYCLES = sfd_ms_to_cycles(longint'(SUBSECT_TYP_MS))
)(
    input  wire logic            ref_clk,
    input  wire logic            srst,
    input  wire sfd_link_in_type link_in,
    output logic                 miso,
    output logic                 miso_oe,
    output logic                 busy
);
    // ------------------------------------------------------------------
    // Serial clock edge detection
    // ------------------------------------------------------------------
    logic sclk_q;
    logic rise;
    logic fall;

    assign rise = link_in.sclk & ~sclk_q;
    assign fall = ~link_in.sclk & sclk_q;

    // ------------------------------------------------------------------
    // Command decode state
    // ------------------------------------------------------------------
    sfd_state_type  state;
    sfd_state_type  next_state;
    logic [7:0]     shreg;
    logic [7:0]     next_shreg;
    logic [4:0]     bitcnt;
    logic [4:0]     next_bitcnt;
    logic [23:0]    addr;
    logic [23:0]    next_addr;
    logic [7:0]     opcode;
    logic [7:0]     next_opcode;
    logic [7:0]     txbyte;
    logic [7:0]     next_txbyte;
    logic           next_miso;
    logic           next_miso_oe;
    logic           load_tx;
    logic           next_load_tx;
    logic [7:0]     rom_data;
    logic [63:0]    timer;
    logic [63:0]    next_timer;
    logic           next_busy;

    sfd_param_rom u_rom (
        .ref_clk (ref_clk),
        .srst    (srst),
        .density (DENSITY),
        // The table sees the next address so its registered data line up with addr.
        .addr    (next_addr[7:0]),
        .rdata   (rom_data)
    );

    // The erase timer counts the bulk worst case and the sector and subsector typical times, so the master sees busy within the bound
    // except bulk erase at 16 and 32 megabit, which runs 200 s against 50 and 100 s; the array itself is not modelled.
    function automatic logic [63:0] erase_time(input logic [7:0] op);
        case (op)
            OP_ERASE_BULK: erase_time = 64'(BULK_CYCLES);
            OP_ERASE_SECT: erase_time = 64'(SECTOR_CYCLES);
            OP_ERASE_SUB:  erase_time = 64'(SUBSECT_CYCLES);
            default:       erase_time = 64'h0;
        endcase
    endfunction : erase_time

    always_comb begin
        next_state   = state;
        next_shreg   = shreg;
        next_bitcnt  = bitcnt;
        next_addr    = addr;
        next_opcode  = opcode;
        next_txbyte  = txbyte;
        next_miso    = miso;
        next_miso_oe = miso_oe;
        next_load_tx = 1'b0;
        next_timer   = timer;
        next_busy    = busy;
        if (busy) begin
            next_timer = timer - 64'h1;
            if (timer == 64'h1) begin
                next_busy = 1'b0;
            end
        end
        if (load_tx) begin
            next_txbyte = rom_data;
        end
        if (link_in.sel_n) begin
            // Deselect ends a command; a latched erase starts here.
            if (state == ST_IGN && erase_time(opcode) != 64'h0 && !busy) begin
                next_busy  = 1'b1;
                next_timer = erase_time(opcode);
            end
            next_state   = ST_IDLE;
            next_miso_oe = 1'b0;
            next_bitcnt  = 5'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state  = ST_OPC;
                    next_bitcnt = 5'h0;
                end
                ST_OPC: begin
                    if (rise) begin
                        next_shreg  = {shreg[6:0], link_in.mosi};
                        next_bitcnt = bitcnt + 5'h1;
                        if (bitcnt == 5'h7) begin
                            next_opcode = {shreg[6:0], link_in.mosi};
                            next_bitcnt = 5'h0;
                            if ({shreg[6:0], link_in.mosi} == OP_READ_PARAM && !busy) begin
                                next_state = ST_ADDR;
                            end else begin
                                next_state = ST_IGN;
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise) begin
                        next_addr   = {addr[22:0], link_in.mosi};
                        next_bitcnt = bitcnt + 5'h1;
                        if (bitcnt == 5'(ADDR_BITS - 1)) begin
                            next_bitcnt = 5'h0;
                            next_state  = ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (rise) begin
                        next_bitcnt = bitcnt + 5'h1;
                        if (bitcnt == 5'(PARAM_DUMMY - 1)) begin
                            next_bitcnt  = 5'h0;
                            next_state   = ST_DATA;
                            next_load_tx = 1'b1;
                        end
                    end
                end
                ST_DATA: begin
                    // Data leaves on the falling edge, MSB first.
                    if (fall) begin
                        next_miso_oe = 1'b1;
                        next_miso    = txbyte[3'(7 - bitcnt[2:0])];
                        next_bitcnt  = bitcnt + 5'h1;
                        if (bitcnt == 5'h7) begin
                            next_bitcnt  = 5'h0;
                            next_addr    = addr + 24'h1;
                            next_load_tx = 1'b1;
                        end
                    end
                end
                ST_IGN: begin
                    next_state = ST_IGN;
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sclk_q  <= 1'b0;
            state   <= ST_IDLE;
            shreg   <= 8'h00;
            bitcnt  <= 5'h0;
            addr    <= 24'h000000;
            opcode  <= 8'h00;
            txbyte  <= 8'h00;
            miso    <= 1'b0;
            miso_oe <= 1'b0;
            load_tx <= 1'b0;
            timer   <= 64'h0;
            busy    <= 1'b0;
        end else begin
            sclk_q  <= link_in.sclk;
            state   <= next_state;
            shreg   <= next_shreg;
            bitcnt  <= next_bitcnt;
            addr    <= next_addr;
            opcode  <= next_opcode;
            txbyte  <= next_txbyte;
            miso    <= next_miso;
            miso_oe <= next_miso_oe;
            load_tx <= next_load_tx;
            timer   <= next_timer;
            busy    <= next_busy;
        end
    end
endmodule : sfd_flash_core
`default_nettype wire

// ==== verif/sfd_flash_core_props.sv ====
// Checker for the serial flash core: output enable, data timing and erase busy.
// Assumes it is bound to sfd_flash_core and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module sfd_flash_core_props
    import sfd_pkg::*;
#(
    parameter longint unsigned BULK_CYCLES    = 20,
    parameter longint unsigned SECTOR_CYCLES  = 20,
    parameter longint unsigned SUBSECT_CYCLES = 20
)(
    input wire logic            ref_clk,
    input wire logic            srst,
    input wire sfd_link_in_type link_in,
    input wire logic            miso,
    input wire logic            miso_oe,
    input wire logic            busy
);
    // ------------------------------------------------------------------
    // Busy run counter
    // ------------------------------------------------------------------
    // Two cycles of slack cover the start-up delay after deselect.
    localparam longint unsigned M1      = BULK_CYCLES > SECTOR_CYCLES ? BULK_CYCLES : SECTOR_CYCLES;
    localparam longint unsigned RUN_MAX = (M1 > SUBSECT_CYCLES ? M1 : SUBSECT_CYCLES) + 2;
    logic [63:0] busy_run;
    logic [63:0] next_busy_run;
    always_comb begin
        next_busy_run = (busy && !srst) ? busy_run + 64'h1 : 64'h0;
    end
    always_ff @(posedge ref_clk) begin
        busy_run <= next_busy_run;
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    sequence s_deselect;
        !link_in.sel_n ##1 link_in.sel_n;
    endsequence
    sequence s_busy_start;
        !busy ##1 busy;
    endsequence
    AST_RST_QUIET: assert property (disable iff (1'b0) srst |=> !busy && !miso_oe && !miso)
        else $error("outputs not quiet after reset");
    AST_OE_DROP: assert property (s_deselect |=> !miso_oe)
        else $error("output enable held after deselect");
    AST_MISO_ON_LOW: assert property ($changed(miso) |-> !link_in.sclk)
        else $error("data changed while serial clock high");
    AST_OE_SELECTED: assert property ($rose(miso_oe) |-> !link_in.sel_n && !busy)
        else $error("output enabled while deselected or busy");
    AST_OE_ON_FALL: assert property ($rose(miso_oe) |-> !link_in.sclk)
        else $error("output enabled outside clock low phase");
    AST_BUSY_MUTE: assert property (busy |-> !miso_oe)
        else $error("read answered during erase");
    AST_BUSY_START: assert property ($rose(busy) |-> link_in.sel_n)
        else $error("erase started while selected");
    AST_BUSY_HOLD: assert property (s_busy_start |-> busy[*8])
        else $error("erase ended too early");
    AST_BUSY_BOUND: assert property (busy |-> busy_run <= RUN_MAX)
        else $error("erase exceeded its limit");
endmodule : sfd_flash_core_props

bind sfd_flash_core sfd_flash_core_props #(
    .BULK_CYCLES(BULK_CYCLES), .SECTOR_CYCLES(SECTOR_CYCLES), .SUBSECT_CYCLES(SUBSECT_CYCLES)
) u_props (
    .ref_clk(ref_clk), .srst(srst), .link_in(link_in), .miso(miso), .miso_oe(miso_oe), .busy(busy)
);
`default_nettype wire

// ==== verif/sfd_master_model.sv ====
// Master-side model of the serial link: drives select, clock and data, captures answers.
// Assumes the core samples the link on ref_clk and needs two cycles per clock phase.
`timescale 1ns/100ps
`default_nettype none
module sfd_master_model
    import sfd_pkg::*;
#(
    parameter int HALF = 4
)(
    input  wire logic           ref_clk,
    output var sfd_link_in_type link_in,
    input  wire logic           miso,
    input  wire logic           miso_oe
);
    // ------------------------------------------------------------------
    // Link tasks
    // ------------------------------------------------------------------
    logic [7:0] rd_buf [256];
    logic       oe_all;
    logic       oe_any;
    initial link_in = '{sel_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
    // Changes land one ns after the edge so the core never races the model.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // Phases of HALF cycles give 12.5 MHz, inside both read clock limits.
    task automatic send_bit(input logic b);
        link_in.mosi = b;
        tick(HALF);
        link_in.sclk = 1'b1;
        tick(HALF);
        link_in.sclk = 1'b0;
    endtask : send_bit
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
    endtask : send_byte
    // A released data line shows the inverse of its last value.
    task automatic deselect();
        tick(HALF);
        link_in.sel_n = 1'b1;
        link_in.mosi  = ~link_in.mosi;
        tick(HALF);
    endtask : deselect
    task automatic read_table(input logic [7:0] a, input int n);
        logic [7:0] v;
        oe_all = 1'b1;
        oe_any = 1'b0;
        link_in.sel_n = 1'b0;
        tick(HALF);
        send_byte(OP_READ_PARAM);
        send_byte(8'h00);
        send_byte(8'h00);
        send_byte(a);
        repeat (PARAM_DUMMY) send_bit(~link_in.mosi);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                tick(HALF);
                link_in.sclk = 1'b1;
                v[i] = miso;
                oe_all = oe_all & miso_oe;
                oe_any = oe_any | miso_oe;
                tick(HALF);
                link_in.sclk = 1'b0;
            end
            rd_buf[8'(a + k)] = v;
        end
        deselect();
    endtask : read_table
    task automatic erase(input logic [7:0] op);
        link_in.sel_n = 1'b0;
        tick(HALF);
        send_byte(op);
        deselect();
    endtask : erase
    // Image payload goes out least-significant bit first, unlike the opcode.
    task automatic write_image(input logic [7:0] op, input logic [7:0] b);
        link_in.sel_n = 1'b0;
        tick(HALF);
        send_byte(op);
        for (int i = 0; i <= 7; i++) begin
            send_bit(b[i]);
        end
        deselect();
    endtask : write_image
endmodule : sfd_master_model
`default_nettype wire

// ==== verif/serial_flash_timing_and_sfdp_test.sv ====
// Self-checking bench for the flash core: table reads, refusal while busy, erase timing.
// Assumes the master model drives the link and the checker binds itself.
`timescale 1ns/100ps
`default_nettype none
module serial_flash_timing_and_sfdp_test
    import sfd_pkg::*;
;
    // ------------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------------
    localparam sfd_density_type DENS        = 2'h1;
    localparam longint unsigned LEN [3]     = '{900, 500, 300};
    localparam logic [7:0]      OPS [3]     = '{OP_ERASE_BULK, OP_ERASE_SECT, OP_ERASE_SUB};
    localparam logic [7:0]      DCODE [4]   = '{8'h00, 8'h01, 8'h03, 8'h07};
    localparam logic [7:0]      SCODE [4]   = '{8'hB3, 8'hC2, 8'hC4, 8'hC9};
    localparam logic [7:0]      HEAD [16]   = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h05, 8'h01, 8'h00, 8'hFF,
                                                8'h00, 8'h05, 8'h01, 8'h10, 8'h80, 8'h00, 8'h00, 8'hFF};
    localparam logic [7:0]      HIGH [54]   = '{8'hE5, 8'h20, 8'hF9, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00,
        8'h44, 8'hEB, 8'h08, 8'h6B, 8'h08, 8'h3B, 8'h42, 8'hBB, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h00, 8'h00, 8'hFF, 8'hFF, 8'h40, 8'hEB, 8'h0C, 8'h20, 8'h0F, 8'h52, 8'h10, 8'hD8, 8'h00, 8'h00,
        8'h36, 8'h02, 8'hA6, 8'h00, 8'h82, 8'hEA, 8'h14, 8'h00, 8'hE9, 8'h63, 8'h76, 8'h33, 8'h7A, 8'h75,
        8'h7A, 8'h75, 8'hF7, 8'hA2};
    logic            ref_clk   = 1'b0;
    logic            srst      = 1'b1;
    wire             sfd_link_in_type link_in;
    wire logic       miso;
    wire logic       miso_oe;
    wire logic       busy;
    int              err_total = 0;
    int              cmp_count = 0;
    longint unsigned run_len   = 0;
    longint unsigned last_len  = 0;
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    sfd_flash_core #(.DENSITY(DENS), .BULK_CYCLES(LEN[0]), .SECTOR_CYCLES(LEN[1]), .SUBSECT_CYCLES(LEN[2]))
        DUT (.ref_clk(ref_clk), .srst(srst), .link_in(link_in), .miso(miso), .miso_oe(miso_oe), .busy(busy));
    sfd_master_model #(.HALF(4)) u_master (.ref_clk(ref_clk), .link_in(link_in), .miso(miso), .miso_oe(miso_oe));
    always @(posedge ref_clk) begin
        if (busy === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            last_len <= run_len;
            run_len  <= 0;
        end
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        return (a == 8'h87) ? DCODE[DENS] : (a == 8'hAB) ? SCODE[DENS] :
               (a < 8'h10) ? HEAD[a[3:0]] : (a < 8'h80) ? 8'hFF : HIGH[a - 8'h80];
    endfunction : exp_byte
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim) begin
            step(1);
            n++;
        end
    endtask : wait_busy
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        $display("[ERR] %0t run did not finish", $time);
        tally_and_finish();
    end
    initial begin
        step(6);
        check({5'h00, busy, miso_oe, miso}, 8'h00, "outputs in reset");
        srst = 1'b0;
        step(1);
        check({5'h00, busy, miso_oe, miso}, 8'h00, "outputs after reset");
        // One long read from 00h; each row is an address and its expected byte.
        u_master.read_table(8'h00, 182);
        check({7'h00, u_master.oe_all}, 8'h01, "output enable during read");
        for (int a = 0; a < 128; a++) begin
            check(u_master.rd_buf[a], exp_byte(8'(a)), "table");
        end
        for (int a = 128; a < 182; a++) begin
            check(u_master.rd_buf[a], exp_byte(8'(a)), "table");
        end
        step(2);
        check({7'h00, miso_oe}, 8'h00, "output enable after deselect");
        u_master.read_table(8'h87, 2);
        check(u_master.rd_buf[8'h87], DCODE[DENS], "density from mid start");
        check(u_master.rd_buf[8'h88], 8'h44, "increment from mid start");
        u_master.rd_buf[0] = 8'h00;
        u_master.read_table(8'hFF, 2);
        check(u_master.rd_buf[0], 8'h53, "address wrap");
        // A non-erase command with an image byte must give no answer and start no timer.
        u_master.write_image(8'h02, 8'hA5);
        step(2);
        check({6'h00, busy, miso_oe}, 8'h00, "image command ignored");
        for (int e = 0; e < 3; e++) begin
            u_master.erase(OPS[e]);
            wait_busy(1'b1, 8);
            check({7'h00, busy}, 8'h01, "erase busy");
            if (e == 0) begin
                u_master.read_table(8'h00, 1);
                check({7'h00, u_master.oe_any}, 8'h00, "read answered while busy");
            end
            wait_busy(1'b0, 3000);
            step(1);
            check({7'h00, last_len + 1 >= LEN[e] && last_len <= LEN[e] + 2}, 8'h01, "erase length");
        end
        u_master.erase(OP_ERASE_SECT);
        wait_busy(1'b1, 8);
        step(20);
        srst = 1'b1;
        step(1);
        check({6'h00, busy, miso_oe}, 8'h00, "busy through reset");
        step(2);
        srst = 1'b0;
        step(2);
        u_master.read_table(8'h00, 1);
        check(u_master.rd_buf[0], 8'h53, "read after reset");
        tally_and_finish();
    end
endmodule : serial_flash_timing_and_sfdp_test
`default_nettype wire
